// ===== nv_port_pkg.sv
// Constants shared by the nonvolatile byte access port
package nv_port_pkg;

  // ----------------------------------------------------------------
  // Array geometry
  // ----------------------------------------------------------------
  localparam int NV_BYTES  = 1024;
  localparam int ADDR_W    = 10;
  localparam int DATA_W    = 8;
  localparam int IO_ADDR_W = 6;

  // ----------------------------------------------------------------
  // I/O-space register indices
  // ----------------------------------------------------------------
  localparam logic [5:0] NV_ADDRESS_HIGH_OFS = 6'h10;
  localparam logic [5:0] NV_ADDRESS_LOW_OFS  = 6'h11;
  localparam logic [5:0] NV_DATA_OFS         = 6'h12;
  localparam logic [5:0] NV_CONTROL_OFS      = 6'h13;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int ADDR_HIGH_BITS   = 2;   // address bits 9..8 live in the high byte
  localparam int READ_STROBE_BIT  = 0;
  localparam int WRITE_STROBE_BIT = 1;
  localparam int WRITE_ARM_BIT    = 2;
  localparam logic [9:0] ADDR_RESET = 10'h000;
  localparam logic [7:0] DATA_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS    = 50;
  localparam int OSC_PERIOD_NS    = 1000;
  localparam int WRITE_OSC_CYCLES = 8448;
  localparam int WRITE_TIME_NS    = WRITE_OSC_CYCLES * OSC_PERIOD_NS;
  localparam int WRITE_CYCLES     = WRITE_TIME_NS / CLK_PERIOD_NS;
  localparam int TIMER_W          = 18;
  localparam logic [2:0] ARM_CYCLES  = 3'h4;
  localparam logic [2:0] READ_STALL  = 3'h4;
  localparam logic [2:0] WRITE_STALL = 3'h2;

  typedef enum logic [1:0] {
    ST_IDLE    = 2'b01,
    ST_WRITING = 2'b10
  } nv_state_t;

endpackage

// ===== nv_byte_array.sv
// Byte-wide storage array of the nonvolatile data space
`timescale 1ns/10ps
`default_nettype none

module nv_byte_array (
  input  wire logic       mclk,      // System clock
  input  wire logic       wr_en,     // Store wr_data at addr
  input  wire logic       rd_en,     // Fetch byte at addr
  input  wire logic [9:0] addr,      // Byte address
  input  wire logic [7:0] wr_data,   // Byte to store
  output logic      [7:0] rd_data    // Fetched byte, valid the cycle after rd_en
);

  // Contents survive reset, as the real storage would
  logic [7:0] mem [nv_port_pkg::NV_BYTES];
  logic [7:0] rd_data_reg;

  always_ff @(posedge mclk) begin
    if (wr_en) begin
      mem[addr] <= wr_data;
    end
    if (rd_en) begin
      rd_data_reg <= mem[addr];
    end
  end

  assign rd_data = rd_data_reg;

endmodule // nv_byte_array
`default_nettype wire

// ===== nv_write_timer.sv
// Self-timed write duration counter
`timescale 1ns/10ps
`default_nettype none

module nv_write_timer #(
  parameter int CYCLES = nv_port_pkg::WRITE_CYCLES
) (
  input  wire logic mclk,      // System clock
  input  wire logic sys_rst,   // Synchronous reset
  input  wire logic start,     // Begin timing one write
  output logic      done       // Pulse in the last cycle of the write time
);

  logic [nv_port_pkg::TIMER_W-1:0] cnt_reg;
  logic [nv_port_pkg::TIMER_W-1:0] cnt_next;

  always_comb begin
    cnt_next = cnt_reg;
    if (start) begin
      cnt_next = nv_port_pkg::TIMER_W'(CYCLES);
    end else if (cnt_reg != '0) begin
      cnt_next = cnt_reg - 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  assign done = (cnt_reg == nv_port_pkg::TIMER_W'(1));

endmodule // nv_write_timer
`default_nettype wire

// ===== nv_access_port.sv
// CPU-side I/O register port to the on-chip nonvolatile data bytes
`timescale 1ns/10ps
`default_nettype none

module nv_access_port #(
  parameter int WRITE_CYCLES = nv_port_pkg::WRITE_CYCLES
) (
  input  wire logic       mclk,       // System clock, 20 MHz
  input  wire logic       sys_rst,    // Synchronous reset, active high
  input  wire logic [5:0] io_addr,    // I/O register index
  input  wire logic       io_wr,      // I/O write strobe
  input  wire logic       io_rd,      // I/O read strobe
  input  wire logic [7:0] io_wdata,   // I/O write data
  output logic      [7:0] io_rdata,   // I/O read data, cycle after io_rd
  output logic            cpu_stall   // Holds the CPU while high
);

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [5:0] a, input logic [5:0] ofs);
    hit = (a == ofs);
  endfunction

  logic wr_high;
  logic wr_low;
  logic wr_data;
  logic wr_ctrl;

  assign wr_high = io_wr && hit(io_addr, nv_port_pkg::NV_ADDRESS_HIGH_OFS);
  assign wr_low  = io_wr && hit(io_addr, nv_port_pkg::NV_ADDRESS_LOW_OFS);
  assign wr_data = io_wr && hit(io_addr, nv_port_pkg::NV_DATA_OFS);
  assign wr_ctrl = io_wr && hit(io_addr, nv_port_pkg::NV_CONTROL_OFS);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  nv_port_pkg::nv_state_t state_reg;
  nv_port_pkg::nv_state_t state_next;
  logic [9:0] addr_reg;
  logic [9:0] addr_next;
  logic [7:0] data_reg;
  logic [7:0] data_next;
  logic [2:0] arm_cnt_reg;
  logic [2:0] arm_cnt_next;
  logic [2:0] stall_cnt_reg;
  logic [2:0] stall_cnt_next;
  logic       read_strobe_reg;
  logic       read_strobe_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;

  logic       master_write_arm;
  logic       write_strobe_busy;
  logic       write_accept;
  logic       read_accept;
  logic       timer_done;
  logic [7:0] mem_rdata;
  logic [7:0] control_view;

  assign master_write_arm  = (arm_cnt_reg != 3'h0);
  assign write_strobe_busy = (state_reg == nv_port_pkg::ST_WRITING);

  // A strobe counts only if the arm bit was already set by an earlier write
  assign write_accept = wr_ctrl && io_wdata[nv_port_pkg::WRITE_STROBE_BIT]
                        && master_write_arm && !write_strobe_busy;
  // Reads are refused while the array is busy programming
  assign read_accept  = wr_ctrl && io_wdata[nv_port_pkg::READ_STROBE_BIT]
                        && !write_strobe_busy && !write_accept;

  assign control_view = {5'h00,
                         master_write_arm,
                         write_strobe_busy,
                         read_strobe_reg};

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    state_next       = state_reg;
    addr_next        = addr_reg;
    data_next        = data_reg;
    arm_cnt_next     = arm_cnt_reg;
    stall_cnt_next   = stall_cnt_reg;
    read_strobe_next = read_strobe_reg;
    rdata_next       = rdata_reg;

    unique case (state_reg)
      nv_port_pkg::ST_IDLE: begin
        if (write_accept) begin
          state_next = nv_port_pkg::ST_WRITING;
        end
      end
      nv_port_pkg::ST_WRITING: begin
        if (timer_done) begin
          state_next = nv_port_pkg::ST_IDLE;
        end
      end
      default: begin
        state_next = nv_port_pkg::ST_IDLE;
      end
    endcase

    // Address is frozen during a write so the byte lands where intended
    if (!write_strobe_busy) begin
      if (wr_high) begin
        addr_next[9:8] = io_wdata[nv_port_pkg::ADDR_HIGH_BITS-1:0];
      end
      if (wr_low) begin
        addr_next[7:0] = io_wdata;
      end
    end

    if (read_strobe_reg) begin
      data_next        = mem_rdata;
      read_strobe_next = 1'b0;
    end else if (wr_data) begin
      data_next = io_wdata;
    end
    if (read_accept) begin
      read_strobe_next = 1'b1;
    end

    // Arming while already armed is ignored; the window never stretches
    if (master_write_arm) begin
      arm_cnt_next = arm_cnt_reg - 3'h1;
    end else if (wr_ctrl && io_wdata[nv_port_pkg::WRITE_ARM_BIT]) begin
      arm_cnt_next = nv_port_pkg::ARM_CYCLES;
    end

    if (read_accept) begin
      stall_cnt_next = nv_port_pkg::READ_STALL;
    end else if (write_accept) begin
      stall_cnt_next = nv_port_pkg::WRITE_STALL;
    end else if (stall_cnt_reg != 3'h0) begin
      stall_cnt_next = stall_cnt_reg - 3'h1;
    end

    rdata_next = 8'h00;
    if (io_rd) begin
      unique case (io_addr)
        nv_port_pkg::NV_ADDRESS_HIGH_OFS: rdata_next = {6'h00, addr_reg[9:8]};
        nv_port_pkg::NV_ADDRESS_LOW_OFS:  rdata_next = addr_reg[7:0];
        nv_port_pkg::NV_DATA_OFS:         rdata_next = data_reg;
        nv_port_pkg::NV_CONTROL_OFS:      rdata_next = control_view;
        default:                          rdata_next = 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state_reg       <= nv_port_pkg::ST_IDLE;
      addr_reg        <= nv_port_pkg::ADDR_RESET;
      data_reg        <= nv_port_pkg::DATA_RESET;
      arm_cnt_reg     <= 3'h0;
      stall_cnt_reg   <= 3'h0;
      read_strobe_reg <= 1'b0;
      rdata_reg       <= 8'h00;
    end else begin
      state_reg       <= state_next;
      addr_reg        <= addr_next;
      data_reg        <= data_next;
      arm_cnt_reg     <= arm_cnt_next;
      stall_cnt_reg   <= stall_cnt_next;
      read_strobe_reg <= read_strobe_next;
      rdata_reg       <= rdata_next;
    end
  end

  assign io_rdata  = rdata_reg;
  assign cpu_stall = (stall_cnt_reg != 3'h0);

  // ----------------------------------------------------------------
  // Storage and write timing
  // ----------------------------------------------------------------
  nv_byte_array nv_byte_array_inst (
    .mclk    (mclk),
    .wr_en   (write_accept),
    .rd_en   (read_accept),
    .addr    (addr_reg),
    .wr_data (data_reg),
    .rd_data (mem_rdata)
  );

  nv_write_timer #(
    .CYCLES (WRITE_CYCLES)
  ) nv_write_timer_inst (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .start   (write_accept),
    .done    (timer_done)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [nv_port_pkg::TIMER_W-1:0] busy_len_reg;
  logic [nv_port_pkg::TIMER_W-1:0] busy_len_next;

  always_comb begin
    busy_len_next = write_strobe_busy ? busy_len_reg + 1'b1 : '0;
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      busy_len_reg <= '0;
    end else begin
      busy_len_reg <= busy_len_next;
    end
  end

  arm_window_a: assert property (
    @(posedge mclk) disable iff (sys_rst)
    $rose(master_write_arm) |-> master_write_arm [*4] ##1 !master_write_arm)
    else $error("arm bit did not hold exactly four cycles");

  unarmed_ignore_a: assert property (
    @(posedge mclk) disable iff (sys_rst)
    (wr_ctrl && io_wdata[nv_port_pkg::WRITE_STROBE_BIT] && !master_write_arm
     && !write_strobe_busy) |=> !write_strobe_busy)
    else $error("write started without arm");

  write_time_a: assert property (
    @(posedge mclk) disable iff (sys_rst)
    $fell(write_strobe_busy) |-> busy_len_reg == nv_port_pkg::TIMER_W'(WRITE_CYCLES))
    else $error("write busy time wrong");

  read_stall_a: assert property (
    @(posedge mclk) disable iff (sys_rst)
    read_accept |=> cpu_stall [*4] ##1 !cpu_stall)
    else $error("read stall not four cycles");

  write_stall_a: assert property (
    @(posedge mclk) disable iff (sys_rst)
    write_accept |=> cpu_stall [*2] ##1 !cpu_stall)
    else $error("write stall not two cycles");

  addr_lock_a: assert property (
    @(posedge mclk) disable iff (sys_rst)
    (write_strobe_busy && (wr_high || wr_low)) |=> $stable(addr_reg))
    else $error("address changed during write");

  read_block_a: assert property (
    @(posedge mclk) disable iff (sys_rst)
    (write_strobe_busy && wr_ctrl && io_wdata[nv_port_pkg::READ_STROBE_BIT])
    |=> !read_strobe_reg)
    else $error("read accepted during write");

  reserved_zero_a: assert property (
    @(posedge mclk) disable iff (sys_rst)
    (io_rd && hit(io_addr, nv_port_pkg::NV_ADDRESS_HIGH_OFS)) |=> io_rdata[7:2] == 6'h00)
    else $error("reserved address bits not zero");

  read_data_a: assert property (
    @(posedge mclk) disable iff (sys_rst)
    read_accept |=> read_strobe_reg ##1 (!read_strobe_reg && data_reg == $past(mem_rdata)))
    else $error("read data not loaded or strobe stuck");

  write_start_a: assert property (
    @(posedge mclk) disable iff (sys_rst)
    write_accept |=> write_strobe_busy && control_view[nv_port_pkg::WRITE_STROBE_BIT])
    else $error("accepted write not shown busy");

  stall_source_a: assert property (
    @(posedge mclk) disable iff (sys_rst)
    (!cpu_stall && !read_accept && !write_accept) |=> !cpu_stall)
    else $error("stall raised without an accepted access");

  busy_hold_a: assert property (
    @(posedge mclk) disable iff (sys_rst)
    (write_strobe_busy && !timer_done) |=> write_strobe_busy)
    else $error("busy dropped before write time");

  rearm_ignore_a: assert property (
    @(posedge mclk) disable iff (sys_rst)
    (master_write_arm && wr_ctrl && io_wdata[nv_port_pkg::WRITE_ARM_BIT])
    |=> arm_cnt_reg == $past(arm_cnt_reg) - 3'h1)
    else $error("arm window stretched by a second arm");

  data_load_a: assert property (
    @(posedge mclk) disable iff (sys_rst)
    (wr_data && !read_strobe_reg) |=> data_reg == $past(io_wdata))
    else $error("data register write lost");

endmodule // nv_access_port
`default_nettype wire

// ===== cpu_model.sv
// CPU core model issuing I/O register reads and writes to the access port
`timescale 1ns/10ps
`default_nettype none

module cpu_model (
  input  wire logic       mclk,        // System clock
  input  wire logic       cpu_stall,   // Hold request from the port
  input  wire logic [7:0] io_rdata,    // Read data
  output logic      [5:0] io_addr,     // Register index
  output logic            io_wr,       // Write request
  output logic            io_rd,       // Read request
  output logic      [7:0] io_wdata,    // Write data
  output logic            hang         // A bounded wait ran out
);
  int stall_seen;

  initial begin
    io_addr = 6'h00;
    io_wr = 1'b0;
    io_rd = 1'b0;
    io_wdata = 8'h00;
    hang = 1'b0;
    stall_seen = 0;
  end

  // A frozen core issues nothing, so every request first waits out a stall
  task automatic wait_free();
    int n;
    n = 0;
    @(negedge mclk);
    while (cpu_stall === 1'b1 && n < 16) begin
      n++;
      @(negedge mclk);
    end
    if (n == 16) hang = 1'b1;
  endtask

  // Callers load the address before an access and arm right before strobing
  task automatic io_write(input logic [5:0] a, input logic [7:0] d);
    wait_free();
    @(posedge mclk);
    io_addr <= a;
    io_wdata <= d;
    io_wr <= 1'b1;
    @(posedge mclk);
    io_wr <= 1'b0;
    io_wdata <= ~d;
    stall_seen = 0;
    @(negedge mclk);
    while (cpu_stall === 1'b1 && stall_seen < 16) begin
      stall_seen++;
      @(negedge mclk);
    end
    if (stall_seen == 16) hang = 1'b1;
  endtask

  task automatic io_read(input logic [5:0] a, output logic [7:0] d);
    wait_free();
    @(posedge mclk);
    io_addr <= a;
    io_rd <= 1'b1;
    @(posedge mclk);
    io_rd <= 1'b0;
    @(negedge mclk);
    d = io_rdata;
  endtask
endmodule // cpu_model

`default_nettype wire

// ===== eeprom_byte_access_port_bench.sv
// Self-checking bench for the nonvolatile byte access port
`timescale 1ns/10ps
`default_nettype none

module eeprom_byte_access_port_bench;
  localparam int WCYC = 20;
  localparam logic [5:0] HI = nv_port_pkg::NV_ADDRESS_HIGH_OFS;
  localparam logic [5:0] LO = nv_port_pkg::NV_ADDRESS_LOW_OFS;
  localparam logic [5:0] DT = nv_port_pkg::NV_DATA_OFS;
  localparam logic [5:0] CT = nv_port_pkg::NV_CONTROL_OFS;

  logic       mclk;
  logic       sys_rst;
  wire  [5:0] io_addr;
  wire        io_wr;
  wire        io_rd;
  wire  [7:0] io_wdata;
  wire  [7:0] io_rdata;
  wire        cpu_stall;
  wire        hang;
  int         error_cnt;
  int         checked;
  logic [7:0] rv;

  nv_access_port #(.WRITE_CYCLES(WCYC)) nv_access_port_inst (
    .mclk(mclk), .sys_rst(sys_rst), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
    .io_wdata(io_wdata), .io_rdata(io_rdata), .cpu_stall(cpu_stall));

  cpu_model cpu_model_inst (
    .mclk(mclk), .cpu_stall(cpu_stall), .io_rdata(io_rdata), .io_addr(io_addr),
    .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .hang(hang));

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  // ----------------------------------------------------------------
  // Shared helpers
  // ----------------------------------------------------------------
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t value %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    cpu_model_inst.io_write(a, d);
  endtask

  task automatic rd_chk(input logic [5:0] a, input logic [7:0] exp);
    cpu_model_inst.io_read(a, rv);
    check(rv, exp);
  endtask

  task automatic set_addr(input logic [9:0] a);
    wr(HI, {6'h3f, a[9:8]});
    wr(LO, a[7:0]);
  endtask

  always @(posedge hang) begin
    error_cnt++;
    give_verdict();
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rd_chk(HI, 8'h00);
    rd_chk(LO, 8'h00);
    rd_chk(DT, 8'h00);
    rd_chk(CT, 8'h00);
    rd_chk(6'h00, 8'h00);
  endtask

  task automatic t_address();
    wr(HI, 8'hff);
    rd_chk(HI, 8'h03);
    wr(LO, 8'ha5);
    rd_chk(LO, 8'ha5);
    wr(DT, 8'h3c);
    rd_chk(DT, 8'h3c);
  endtask

  task automatic t_write(input logic [9:0] a, input logic [7:0] d, input bit probe);
    int k;
    time t0;
    set_addr(a);
    wr(DT, d);
    wr(CT, 8'h04);
    wr(CT, 8'h06);
    t0 = $time;
    check(8'(cpu_model_inst.stall_seen), 8'h02);
    rd_chk(CT, 8'h02);
    if (probe) begin
      wr(LO, ~a[7:0]);
      wr(CT, 8'h01);
      check(8'(cpu_model_inst.stall_seen), 8'h00);
    end
    k = 0;
    rv = 8'h02;
    while (rv[1] !== 1'b0 && k < 60) begin
      cpu_model_inst.io_read(CT, rv);
      k++;
    end
    if (k == 60) begin
      error_cnt++;
      give_verdict();
    end
    k = int'(($time - t0) / 50);
    check({7'h00, k >= WCYC + 1 && k <= WCYC + 3}, 8'h01);
    if (probe) rd_chk(LO, a[7:0]);
  endtask

  task automatic t_refused();
    set_addr(10'h3a5);
    wr(DT, 8'hee);
    wr(CT, 8'h02);
    check(8'(cpu_model_inst.stall_seen), 8'h00);
    rd_chk(CT, 8'h00);
    wr(CT, 8'h06);
    check(8'(cpu_model_inst.stall_seen), 8'h00);
    repeat (6) @(posedge mclk);
    rd_chk(CT, 8'h00);
  endtask

  task automatic t_arm_timeout();
    wr(CT, 8'h04);
    rd_chk(CT, 8'h04);
    repeat (4) @(posedge mclk);
    rd_chk(CT, 8'h00);
    wr(CT, 8'h02);
    check(8'(cpu_model_inst.stall_seen), 8'h00);
    rd_chk(CT, 8'h00);
  endtask

  task automatic t_read(input logic [9:0] a, input logic [7:0] d);
    set_addr(a);
    wr(DT, ~d);
    wr(CT, 8'h01);
    check(8'(cpu_model_inst.stall_seen), 8'h04);
    rd_chk(CT, 8'h00);
    rd_chk(DT, d);
  endtask

  // Reset in mid-write aborts the busy bit; the byte was already stored
  task automatic t_mid_reset(input logic [9:0] a, input logic [7:0] d);
    set_addr(a);
    wr(DT, d);
    wr(CT, 8'h04);
    wr(CT, 8'h02);
    rd_chk(CT, 8'h02);
    @(posedge mclk);
    sys_rst <= 1'b1;
    repeat (4) @(posedge mclk);
    sys_rst <= 1'b0;
    t_reset();
    t_read(a, d);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    error_cnt = 0;
    checked = 0;
    sys_rst = 1'b1;
    repeat (20) @(posedge mclk);
    sys_rst <= 1'b0;
    t_reset();
    t_address();
    t_write(10'h3a5, 8'h77, 1'b1);
    t_refused();
    t_arm_timeout();
    t_write(10'h3ff, 8'h5c, 1'b0);
    t_write(10'h000, 8'ha3, 1'b0);
    t_read(10'h3a5, 8'h77);
    t_read(10'h3ff, 8'h5c);
    t_read(10'h000, 8'ha3);
    t_mid_reset(10'h155, 8'h6e);
    give_verdict();
  end
endmodule // eeprom_byte_access_port_bench

`default_nettype wire
